/* fsp_pkg.sv */
// Shared constants, command codes and carriers of the flash self-program block
package fsp_pkg;

  // Widths
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 8;
  localparam int CMD_W   = 3;
  localparam int PROT_W  = 5;
  localparam int BLOCK_W = 4;
  localparam int ERR_N   = 3;

  // Peripheral register addresses
  localparam logic [ADDR_W-1:0] ADDR_KEY  = 16'hffa0;
  localparam logic [ADDR_W-1:0] ADDR_ERR  = 16'hffa1;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 16'hffa2;
  localparam logic [ADDR_W-1:0] ADDR_CMD  = 16'hffa3;
  localparam logic [ADDR_W-1:0] ADDR_PTRH = 16'hffa4;
  localparam logic [ADDR_W-1:0] ADDR_PTRL = 16'hffa5;
  localparam logic [ADDR_W-1:0] ADDR_CMPH = 16'hffa6;
  localparam logic [ADDR_W-1:0] ADDR_CMPL = 16'hffa7;
  localparam logic [ADDR_W-1:0] ADDR_WBUF = 16'hffa8;

  // Unlock key value
  localparam logic [DATA_W-1:0] UNLOCK_KEY = 8'ha5;

  // Error status bit positions
  localparam int ERR_UNLOCK_BIT = 0;
  localparam int ERR_VERIFY_BIT = 1;
  localparam int ERR_PROT_BIT   = 2;

  // Mode control field positions
  localparam int MODE_SEL_BIT  = 0;
  localparam int MODE_PROT_LSB = 2;

  // Reset values
  localparam logic [DATA_W-1:0] ERR_RESET  = 8'h00;
  localparam logic [CMD_W-1:0]  CMD_RESET  = 3'h0;
  localparam logic [DATA_W-1:0] PTR_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] CMP_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] WBUF_RESET = 8'h00;
  localparam logic [PROT_W-1:0] PROT_RESET = 5'h1f;

  // Command codes
  localparam logic [CMD_W-1:0] CMD_VERIFY = 3'h1;
  localparam logic [CMD_W-1:0] CMD_ERASE  = 3'h3;
  localparam logic [CMD_W-1:0] CMD_BLANK  = 3'h4;
  localparam logic [CMD_W-1:0] CMD_WRITE  = 3'h5;

  // Protect setting decode: top bit set opens all blocks
  localparam int                PROT_OPEN_BIT = 4;
  localparam logic [PROT_W-1:0] PROT_SPAN     = 5'h10;

  // Register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fsp_bus_req_s;

  // Request to the flash array
  typedef struct packed {
    logic              req;
    logic [CMD_W-1:0]  op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fsp_flash_req_s;

  // Answer from the flash array
  typedef struct packed {
    logic done;
    logic fail;
  } fsp_flash_rsp_s;

endpackage

/* fsp_protect.sv */
// Block protection decode from the protect setting
`timescale 1ns/1ps
`default_nettype none

module fsp_protect
(
  // Protect setting and selected block
  input  wire logic [fsp_pkg::PROT_W-1:0]  prot_setting,
  input  wire logic [fsp_pkg::BLOCK_W-1:0] block,
  // Decode result
  output logic                             is_protected
);

  logic [fsp_pkg::PROT_W-1:0] pair_limit;
  logic [fsp_pkg::PROT_W-1:0] pair_index;

  // Blocks are locked in pairs from block 0 upward
  always_comb
  begin
    pair_limit = fsp_pkg::PROT_SPAN
                 - {1'b0, prot_setting[fsp_pkg::BLOCK_W-1:0]};
    pair_index = {2'b00, block[fsp_pkg::BLOCK_W-1:1]};
    is_protected = !prot_setting[fsp_pkg::PROT_OPEN_BIT]
                   && (pair_index < pair_limit);
  end

endmodule

`default_nettype wire

/* fsp_unlock.sv */
// Keyed unlock sequence tracker guarding the mode control register
`timescale 1ns/1ps
`default_nettype none

module fsp_unlock
(
  // Clock, reset and clock enable
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  // Classified peripheral store
  input  wire logic                        store,
  input  wire logic                        store_key,
  input  wire logic                        store_mode,
  input  wire logic [fsp_pkg::DATA_W-1:0]  store_data,
  // Outcome
  output logic                             commit,
  output logic [fsp_pkg::DATA_W-1:0]       commit_val,
  output logic                             seq_error
);

  typedef enum logic [1:0] {U_IDLE, U_KEYED, U_VALUE, U_INVERSE} fsp_useq_e;

  fsp_useq_e                  state_q;
  fsp_useq_e                  state_d;
  logic [fsp_pkg::DATA_W-1:0] value_q;

  // Next state and outcome of each store
  always_comb
  begin
    state_d   = state_q;
    commit    = 1'b0;
    seq_error = 1'b0;
    if (store)
    begin
      case (state_q)
        U_IDLE:
        begin
          if (store_key && store_data == fsp_pkg::UNLOCK_KEY)
            state_d = U_KEYED;
          else if (store_key || store_mode)
            seq_error = 1'b1;
        end
        U_KEYED:
        begin
          if (store_mode)
            state_d = U_VALUE;
          else
            seq_error = 1'b1;
        end
        U_VALUE:
        begin
          if (store_mode && store_data == ~value_q)
            state_d = U_INVERSE;
          else
            seq_error = 1'b1;
        end
        U_INVERSE:
        begin
          if (store_mode && store_data == value_q)
            commit = 1'b1;
          else
            seq_error = 1'b1;
          state_d = U_IDLE;
        end
        default:
          state_d = U_IDLE;
      endcase
      if (seq_error)
        state_d = U_IDLE;
    end
  end

  // Tracker state; one key covers one update only
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= U_IDLE;
    else if (clk_en)
      state_q <= state_d;
  end

  // Target value of the first store
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      value_q <= '0;
    else if (clk_en && store && store_mode && state_q == U_KEYED)
      value_q <= store_data;
  end

  assign commit_val = value_q;

endmodule

`default_nettype wire

/* fsp_control.sv */
// Flash self-programming control: registers, unlock guard, command engine
// How it works
// - Mode control changes need the A5 key stored first.
// - Value and inverse stores are ignored; third matching store updates.
// - A broken sequence leaves mode unchanged and sets unlock error.
// - Key register store of anything but A5 sets unlock error.
// - A store to another register mid-sequence sets unlock error.
// - Wrong inverse or wrong repeated value sets unlock error.
// - Error flags stay set until written 0 or reset.
// - Error status: bit0 unlock, bit1 verify, bit2 protect; reset 00.
// - Failed erase or write verification sets verify error.
// - A protection refusal also sets verify error.
// - Erase or write on a protected block sets protected-area error.
// - Command codes: 1 verify, 3 erase, 4 blank check, 5 write.
// - Prohibited code cancels the mode, runs nothing, sets no flag.
// - Command register resets to 00, upper bits read zero.
// - Pointers count up to the compare values; reload per command.
// - The CPU is held while a command runs.
// - Interrupts are deferred while self-programming mode is set.
// - Mode bit 0 selects self-programming; cleared at reset.
`timescale 1ns/1ps
`default_nettype none

module fsp_control
(
  // Clock, reset and clock enable
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  // Register port
  input  wire fsp_pkg::fsp_bus_req_s   bus_req,
  output logic [fsp_pkg::DATA_W-1:0]   bus_rdata,
  // CPU side
  input  wire logic                    halt_req,
  output logic                         cpu_hold,
  output logic                         irq_defer,
  output logic                         selfprog_mode_select,
  output logic                         cmd_done,
  // Protect setting read from the flash
  input  wire logic [fsp_pkg::PROT_W-1:0] protect_setting,
  // Flash array
  output fsp_pkg::fsp_flash_req_s      flash_req,
  input  wire fsp_pkg::fsp_flash_rsp_s flash_rsp
);

  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ISSUE, S_WAIT, S_STEP}
    fsp_state_e;

  // Register state
  logic [fsp_pkg::ERR_N-1:0]  err_q;
  logic [fsp_pkg::CMD_W-1:0]  cmd_q;
  logic [fsp_pkg::DATA_W-1:0] ptrh_q;
  logic [fsp_pkg::DATA_W-1:0] ptrl_q;
  logic [fsp_pkg::DATA_W-1:0] cmph_q;
  logic [fsp_pkg::DATA_W-1:0] cmpl_q;
  logic [fsp_pkg::DATA_W-1:0] wbuf_q;
  logic [fsp_pkg::DATA_W-1:0] key_q;
  logic [fsp_pkg::PROT_W-1:0] prot_q;
  logic                       prot_loaded_q;
  logic                       mode_q;
  logic [fsp_pkg::DATA_W-1:0] rdata_q;
  logic [fsp_pkg::DATA_W-1:0] rdata_d;

  // Engine state
  fsp_state_e                 state_q;
  fsp_state_e                 state_d;
  logic                       done_q;
  fsp_pkg::fsp_flash_req_s    freq_q;

  // Decoded strobes and engine events
  logic                       wr;
  logic                       wr_key;
  logic                       wr_mode;
  logic                       cmd_valid;
  logic                       cmd_guarded;
  logic                       blk_protected;
  logic                       cancel;
  logic                       step_inc;
  logic [fsp_pkg::ERR_N-1:0]  err_set;
  logic [fsp_pkg::ERR_N-1:0]  err_clr;
  logic                       seq_commit;
  logic [fsp_pkg::DATA_W-1:0] seq_value;
  logic                       seq_error;
  logic [2*fsp_pkg::DATA_W-1:0] ptr_next;

  // Store classification
  assign wr      = bus_req.wr;
  assign wr_key  = wr && bus_req.addr == fsp_pkg::ADDR_KEY;
  assign wr_mode = wr && bus_req.addr == fsp_pkg::ADDR_MODE;

  // Unlock sequence tracker sees every peripheral store
  fsp_unlock u_unlock
  (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .store      (wr),
    .store_key  (wr_key),
    .store_mode (wr_mode),
    .store_data (bus_req.wdata),
    .commit     (seq_commit),
    .commit_val (seq_value),
    .seq_error  (seq_error)
  );

  // Protection of the block named by the high pointer
  fsp_protect u_protect
  (
    .prot_setting (prot_q),
    .block        (ptrh_q[fsp_pkg::BLOCK_W-1:0]),
    .is_protected (blk_protected)
  );

  always_comb
  begin
    case (cmd_q)
      fsp_pkg::CMD_VERIFY,
      fsp_pkg::CMD_ERASE,
      fsp_pkg::CMD_BLANK,
      fsp_pkg::CMD_WRITE: cmd_valid = 1'b1;
      default:            cmd_valid = 1'b0;
    endcase
  end

  // Only erase and write are refused on a locked block
  assign cmd_guarded = cmd_q == fsp_pkg::CMD_ERASE
                       || cmd_q == fsp_pkg::CMD_WRITE;

  // Command engine next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
        if (halt_req && mode_q)
          state_d = S_CHECK;
      S_CHECK:
        if (!cmd_valid || (cmd_guarded && blk_protected))
          state_d = S_IDLE;
        else
          state_d = S_ISSUE;
      S_ISSUE:
        state_d = S_WAIT;
      S_WAIT:
        if (flash_rsp.done)
          state_d = S_STEP;
      S_STEP:
        if (ptrh_q == cmph_q && ptrl_q == cmpl_q)
          state_d = S_IDLE;
        else
          state_d = S_ISSUE;
      default:
        state_d = S_IDLE;
    endcase
  end

  assign cancel   = state_q == S_CHECK && !cmd_valid;
  assign step_inc = state_q == S_STEP && state_d == S_ISSUE;
  assign ptr_next = {ptrh_q, ptrl_q} + 16'h0001;

  // Engine state register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= S_IDLE;
    else if (clk_en)
      state_q <= state_d;
  end

  // Completion pulse; a cancel is not a completion
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      done_q <= 1'b0;
    else if (clk_en)
      done_q <= state_q == S_STEP && state_d == S_IDLE
                || (state_q == S_CHECK && cmd_valid && state_d == S_IDLE);
  end

  // Flash request: one-cycle pulse with operands held
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      freq_q <= '0;
    else if (clk_en)
    begin
      freq_q.req <= state_q == S_ISSUE;
      if (state_q == S_ISSUE)
      begin
        freq_q.op    <= cmd_q;
        freq_q.addr  <= {ptrh_q, ptrl_q};
        freq_q.wdata <= wbuf_q;
      end
    end
  end

  // Error flag sources
  always_comb
  begin
    err_set = '0;
    err_set[fsp_pkg::ERR_UNLOCK_BIT] = seq_error;
    err_set[fsp_pkg::ERR_VERIFY_BIT] = state_q == S_WAIT
                                       && flash_rsp.done && flash_rsp.fail;
    err_set[fsp_pkg::ERR_PROT_BIT] = state_q == S_CHECK && cmd_valid
                                     && cmd_guarded && blk_protected;
    if (err_set[fsp_pkg::ERR_PROT_BIT])
      err_set[fsp_pkg::ERR_VERIFY_BIT] = 1'b1;
  end

  // Writing 0 clears only that flag
  assign err_clr = (wr && bus_req.addr == fsp_pkg::ADDR_ERR)
                   ? ~bus_req.wdata[fsp_pkg::ERR_N-1:0] : '0;

  for (genvar i = 0; i < fsp_pkg::ERR_N; i++)
  begin : g_err
    always_ff @(posedge sys_clk)
    begin
      if (sys_rst)
        err_q[i] <= fsp_pkg::ERR_RESET[i];
      else if (clk_en)
        err_q[i] <= err_set[i] | (err_q[i] & ~err_clr[i]);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      mode_q <= 1'b0;
    else if (clk_en)
    begin
      if (cancel)
        mode_q <= 1'b0;
      else if (seq_commit)
        mode_q <= seq_value[fsp_pkg::MODE_SEL_BIT];
    end
  end

  // Protect setting caught once after reset release
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prot_q        <= fsp_pkg::PROT_RESET;
      prot_loaded_q <= 1'b0;
    end
    else if (clk_en && !prot_loaded_q)
    begin
      prot_q        <= protect_setting;
      prot_loaded_q <= 1'b1;
    end
  end

  // command register, upper bits fixed zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      cmd_q <= fsp_pkg::CMD_RESET;
    else if (clk_en && wr && bus_req.addr == fsp_pkg::ADDR_CMD)
      cmd_q <= bus_req.wdata[fsp_pkg::CMD_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ptrh_q <= fsp_pkg::PTR_RESET;
      ptrl_q <= fsp_pkg::PTR_RESET;
    end
    else if (clk_en)
    begin
      if (step_inc)
        {ptrh_q, ptrl_q} <= ptr_next;
      else
      begin
        if (wr && bus_req.addr == fsp_pkg::ADDR_PTRH)
          ptrh_q <= bus_req.wdata;
        if (wr && bus_req.addr == fsp_pkg::ADDR_PTRL)
          ptrl_q <= bus_req.wdata;
      end
    end
  end

  // Compare, write buffer and key registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cmph_q <= fsp_pkg::CMP_RESET;
      cmpl_q <= fsp_pkg::CMP_RESET;
      wbuf_q <= fsp_pkg::WBUF_RESET;
      key_q  <= '0;
    end
    else if (clk_en && wr)
    begin
      if (bus_req.addr == fsp_pkg::ADDR_CMPH)
        cmph_q <= bus_req.wdata;
      if (bus_req.addr == fsp_pkg::ADDR_CMPL)
        cmpl_q <= bus_req.wdata;
      if (bus_req.addr == fsp_pkg::ADDR_WBUF)
        wbuf_q <= bus_req.wdata;
      if (wr_key)
        key_q <= bus_req.wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    case (bus_req.addr)
      fsp_pkg::ADDR_KEY:  rdata_d = key_q;
      fsp_pkg::ADDR_ERR:  rdata_d[fsp_pkg::ERR_N-1:0] = err_q;
      fsp_pkg::ADDR_MODE:
      begin
        rdata_d[fsp_pkg::MODE_SEL_BIT] = mode_q;
        rdata_d[fsp_pkg::MODE_PROT_LSB +: fsp_pkg::PROT_W] = prot_q;
      end
      fsp_pkg::ADDR_CMD:  rdata_d[fsp_pkg::CMD_W-1:0] = cmd_q;
      fsp_pkg::ADDR_PTRH: rdata_d = ptrh_q;
      fsp_pkg::ADDR_PTRL: rdata_d = ptrl_q;
      fsp_pkg::ADDR_CMPH: rdata_d = cmph_q;
      fsp_pkg::ADDR_CMPL: rdata_d = cmpl_q;
      fsp_pkg::ADDR_WBUF: rdata_d = wbuf_q;
      default:            rdata_d = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else if (clk_en)
      rdata_q <= bus_req.rd ? rdata_d : '0;
  end

  // Outputs
  assign bus_rdata            = rdata_q;
  assign flash_req            = freq_q;
  assign cmd_done             = done_q;
  assign selfprog_mode_select = mode_q;
  assign cpu_hold             = state_q != S_IDLE;
  assign irq_defer            = mode_q;

endmodule

`default_nettype wire

/* fsp_control_sva.sv */
// Port assertions for the flash self-program control block
`timescale 1ns/1ps
`default_nettype none

module fsp_control_sva
(
  // Clock, reset and enable
  input wire logic                       sys_clk,
  input wire logic                       sys_rst,
  input wire logic                       clk_en,
  // Register port
  input wire fsp_pkg::fsp_bus_req_s      bus_req,
  input wire logic [fsp_pkg::DATA_W-1:0] bus_rdata,
  // CPU side
  input wire logic                       halt_req,
  input wire logic                       cpu_hold,
  input wire logic                       irq_defer,
  input wire logic                       selfprog_mode_select,
  input wire logic                       cmd_done,
  // Flash array
  input wire fsp_pkg::fsp_flash_req_s    flash_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [2:0]  code_q;
  logic [15:0] addr_q;
  logic        seen_q;
  logic        bad_code;
  logic        start;

  // Shadow of the command code, since the register is not a port
  always_ff @(posedge sys_clk)
    if (sys_rst)
      code_q <= 3'h0;
    else if (clk_en && bus_req.wr && bus_req.addr == fsp_pkg::ADDR_CMD)
      code_q <= bus_req.wdata[2:0];

  // Last flash address; first request of a command has no predecessor
  always_ff @(posedge sys_clk)
    if (sys_rst || cmd_done)
      seen_q <= 1'b0;
    else if (flash_req.req)
      seen_q <= 1'b1;
  always_ff @(posedge sys_clk)
    if (flash_req.req)
      addr_q <= flash_req.addr;

  // Command start and prohibited code decode
  assign start = halt_req && selfprog_mode_select && !cpu_hold;
  assign bad_code = !(code_q inside {fsp_pkg::CMD_VERIFY, fsp_pkg::CMD_ERASE,
                                     fsp_pkg::CMD_BLANK, fsp_pkg::CMD_WRITE});

  a_defer_follows_mode: assert property (
    irq_defer == selfprog_mode_select)
    else $error("interrupt defer differs from mode bit");
  a_mode_by_store: assert property (
    $rose(selfprog_mode_select) |-> $past(bus_req.wr) && $past(bus_req.wdata[0])
      && $past(bus_req.addr) == fsp_pkg::ADDR_MODE)
    else $error("mode set without a final mode store");
  a_hold_on_start: assert property (
    start |=> cpu_hold)
    else $error("cpu not held after command start");
  a_done_ends_hold: assert property (
    cmd_done |-> !cpu_hold && $past(cpu_hold))
    else $error("done pulse not at end of hold");
  a_req_code_match: assert property (
    flash_req.req |-> cpu_hold && selfprog_mode_select && flash_req.op == code_q)
    else $error("flash request with wrong code or outside mode");
  a_ptr_counts_up: assert property (
    flash_req.req && seen_q |-> flash_req.addr == addr_q + 16'h0001)
    else $error("flash address did not step by one");
  a_cancel_mode: assert property (
    start && bad_code |-> ##2 !selfprog_mode_select)
    else $error("prohibited code did not cancel mode");
  a_cancel_quiet: assert property (
    start && bad_code |=> (!flash_req.req && !cmd_done) [*4])
    else $error("prohibited code ran or finished");
  a_err_upper_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == fsp_pkg::ADDR_ERR
      |-> bus_rdata[7:3] == 5'h00)
    else $error("status upper bits not zero");
  a_cmd_upper_zero: assert property (
    $past(bus_req.rd) && $past(bus_req.addr) == fsp_pkg::ADDR_CMD
      |-> bus_rdata[7:3] == 5'h00)
    else $error("command upper bits not zero");
endmodule

bind fsp_control fsp_control_sva chk
(
  .sys_clk              (sys_clk),
  .sys_rst              (sys_rst),
  .clk_en               (clk_en),
  .bus_req              (bus_req),
  .bus_rdata            (bus_rdata),
  .halt_req             (halt_req),
  .cpu_hold             (cpu_hold),
  .irq_defer            (irq_defer),
  .selfprog_mode_select (selfprog_mode_select),
  .cmd_done             (cmd_done),
  .flash_req            (flash_req)
);
`default_nettype wire

/* fsp_flash_model.sv */
// Behavioural flash array answering one request at a time
`timescale 1ns/1ps
`default_nettype none

module fsp_flash_model
(
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Scenario controls
  input  wire logic [3:0]              lat,
  input  wire logic                    fail_en,
  // Request and answer
  input  wire fsp_pkg::fsp_flash_req_s flash_req,
  output var fsp_pkg::fsp_flash_rsp_s  flash_rsp
);
  logic       busy_q;
  logic [3:0] wait_q;

  // Answer lat+2 cycles after the request pulse; fail toggles when not valid to expose misuse
  always_ff @(posedge sys_clk)
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      flash_rsp <= '0;
    end
    else
    begin
      flash_rsp.done <= 1'b0;
      flash_rsp.fail <= ~flash_rsp.fail;
      if (flash_req.req)
      begin
        busy_q <= 1'b1;
        wait_q <= lat;
      end
      else if (busy_q && wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (busy_q)
      begin
        busy_q <= 1'b0;
        flash_rsp.done <= 1'b1;
        flash_rsp.fail <= fail_en;
      end
    end
endmodule
`default_nettype wire

/* test_flash_self_program_control.sv */
// Self-checking bench for the flash self-program control block
`timescale 1ns/1ps
`default_nettype none

module test_flash_self_program_control;
  logic                    sys_clk;
  logic                    sys_rst;
  logic                    clk_en;
  logic                    halt_req;
  logic                    cpu_hold;
  logic                    irq_defer;
  logic                    mode;
  logic                    cmd_done;
  logic                    fail_en;
  logic [3:0]              lat;
  logic [7:0]              bus_rdata;
  fsp_pkg::fsp_bus_req_s   bus_req;
  fsp_pkg::fsp_flash_req_s flash_req;
  fsp_pkg::fsp_flash_rsp_s flash_rsp;
  int                      bad_count;
  int                      checks_done;

  // Protect setting 0f guards blocks 0 and 1
  fsp_control uut
  (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .clk_en               (clk_en),
    .bus_req              (bus_req),
    .bus_rdata            (bus_rdata),
    .halt_req             (halt_req),
    .cpu_hold             (cpu_hold),
    .irq_defer            (irq_defer),
    .selfprog_mode_select (mode),
    .cmd_done             (cmd_done),
    .protect_setting      (5'h0f),
    .flash_req            (flash_req),
    .flash_rsp            (flash_rsp)
  );

  fsp_flash_model fm
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .lat       (lat),
    .fail_en   (fail_en),
    .flash_req (flash_req),
    .flash_rsp (flash_rsp)
  );

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // One-cycle write; strobes stay up between back-to-back writes
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
  endtask

  // Read, then compare data and mode bit mid-cycle where both are settled
  task automatic rd_is(input logic [15:0] a, input logic [7:0] e,
                       input logic em);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    bus_req <= '0;
    @(negedge sys_clk);
    chk_byte(bus_rdata, e);
    chk_bit(mode, em);
    chk_bit(irq_defer, em);
    @(posedge sys_clk);
  endtask

  task automatic unl(input logic [7:0] v);
    wr(fsp_pkg::ADDR_KEY, fsp_pkg::UNLOCK_KEY);
    wr(fsp_pkg::ADDR_MODE, v);
    wr(fsp_pkg::ADDR_MODE, ~v);
    wr(fsp_pkg::ADDR_MODE, v);
  endtask

  // Load registers, start, count requests until done or the bound
  task automatic run_cmd(input logic [2:0] c, input logic [7:0] ph,
                         input logic [7:0] pl, input logic [7:0] cl,
                         input logic want, output int nr, output logic dn);
    wr(fsp_pkg::ADDR_ERR, 8'h00);
    wr(fsp_pkg::ADDR_CMD, {5'h00, c});
    wr(fsp_pkg::ADDR_PTRH, ph);
    wr(fsp_pkg::ADDR_PTRL, pl);
    wr(fsp_pkg::ADDR_CMPH, ph);
    wr(fsp_pkg::ADDR_CMPL, cl);
    bus_req <= '0;
    repeat (640) @(posedge sys_clk);
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    nr = 0;
    dn = 1'b0;
    for (int i = 0; i < 60 && !dn; i++)
    begin
      @(negedge sys_clk);
      if (flash_req.req === 1'b1)
      begin
        nr++;
        chk_byte({5'h00, flash_req.op}, {5'h00, c});
      end
      dn = (cmd_done === 1'b1);
    end
    @(posedge sys_clk);
    if (want && !dn)
    begin
      bad_count++;
      $display("unexpected at %0t: command did not finish", $time);
      conclude();
    end
  endtask

  task automatic s_bad_unlock();
    logic [11:0] sq [6][4];
    int          n [6];
    // Entries hold register offset nibble and data
    sq = '{'{12'h05a, 12'h000, 12'h000, 12'h000},
           '{12'h0a5, 12'h400, 12'h000, 12'h000},
           '{12'h0a5, 12'h201, 12'h2ff, 12'h000},
           '{12'h0a5, 12'h201, 12'h2fe, 12'h203},
           '{12'h201, 12'h000, 12'h000, 12'h000},
           '{12'h0a5, 12'h700, 12'h2fe, 12'h201}};
    n = '{1, 2, 3, 4, 1, 4};
    for (int s = 0; s < 6; s++)
    begin
      for (int k = 0; k < n[s]; k++)
        wr(fsp_pkg::ADDR_KEY + 16'(sq[s][k][11:8]), sq[s][k][7:0]);
      rd_is(fsp_pkg::ADDR_ERR, 8'h01, 1'b0);
      wr(fsp_pkg::ADDR_ERR, 8'h00);
      rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b0);
    end
  endtask

  task automatic s_commands();
    logic [2:0] cs [4];
    int         nr;
    logic       dn;
    cs = '{fsp_pkg::CMD_VERIFY, fsp_pkg::CMD_ERASE,
           fsp_pkg::CMD_BLANK, fsp_pkg::CMD_WRITE};
    for (int i = 0; i < 4; i++)
    begin
      lat <= 4'(i * 3);
      run_cmd(cs[i], 8'h02, 8'h10, 8'h12, 1'b1, nr, dn);
      chk_byte(8'(nr), 8'h03);
      rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b1);
    end
  endtask

  task automatic s_faults();
    int   nr;
    logic dn;
    run_cmd(fsp_pkg::CMD_ERASE, 8'h01, 8'h00, 8'h00, 1'b1, nr, dn);
    chk_byte(8'(nr), 8'h00);
    rd_is(fsp_pkg::ADDR_ERR, 8'h06, 1'b1);
    wr(fsp_pkg::ADDR_ERR, 8'h04);
    rd_is(fsp_pkg::ADDR_ERR, 8'h04, 1'b1);
    wr(fsp_pkg::ADDR_ERR, 8'h00);
    wr(fsp_pkg::ADDR_WBUF, 8'h3c);
    fail_en <= 1'b1;
    run_cmd(fsp_pkg::CMD_WRITE, 8'h03, 8'h20, 8'h20, 1'b1, nr, dn);
    fail_en <= 1'b0;
    chk_byte(flash_req.wdata, 8'h3c);
    chk_byte(flash_req.addr[7:0], 8'h20);
    chk_byte(8'(nr), 8'h01);
    rd_is(fsp_pkg::ADDR_ERR, 8'h02, 1'b1);
    wr(fsp_pkg::ADDR_ERR, 8'h00);
  endtask

  task automatic s_bad_code();
    logic [2:0] cs [4];
    int         nr;
    logic       dn;
    cs = '{3'h0, 3'h2, 3'h6, 3'h7};
    for (int i = 0; i < 4; i++)
    begin
      unl(8'h01);
      run_cmd(cs[i], 8'h02, 8'h00, 8'h00, 1'b0, nr, dn);
      chk_byte(8'(nr), 8'h00);
      chk_bit(dn, 1'b0);
      rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b0);
    end
    // Start with the mode off must be ignored
    halt_req <= 1'b1;
    @(posedge sys_clk);
    halt_req <= 1'b0;
    @(negedge sys_clk);
    chk_bit(cpu_hold, 1'b0);
    @(posedge sys_clk);
  endtask

  initial
  begin
    bad_count = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    halt_req = 1'b0;
    fail_en = 1'b0;
    lat = 4'h2;
    bus_req = '0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b0);
    rd_is(fsp_pkg::ADDR_CMD, 8'h00, 1'b0);
    s_bad_unlock();
    unl(8'h01);
    rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b1);
    s_commands();
    s_faults();
    s_bad_code();
    unl(8'h01);
    unl(8'h00);
    rd_is(fsp_pkg::ADDR_ERR, 8'h00, 1'b0);
    // Store while frozen must be lost
    clk_en <= 1'b0;
    wr(fsp_pkg::ADDR_CMD, 8'h05);
    clk_en <= 1'b1;
    rd_is(fsp_pkg::ADDR_CMD, 8'h07, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
